//--- adc_out_params.svh
// Constants for the converter parallel output interface
`ifndef ADC_OUT_PARAMS_SVH
`define ADC_OUT_PARAMS_SVH

// Sample word
`define SAMPLE_W 12
`define CODE_MAX 2047
`define CODE_MIN (-2048)
`define GRAY_OFFSET 12'h800
`define ANALOG_W_DEF 14

// Timing
`define CLK_PERIOD_PS 8000
`define DAV_DELAY_PS 6400
`define DAV_DELAY_CYC (((`DAV_DELAY_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS) < 1 ? 1 : \
  ((`DAV_DELAY_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))
`define LATENCY_FALLS 8
`define PIPE_DEPTH (`LATENCY_FALLS + 1)
`define LOCK_CYCLES 100
`define PERIOD_W 16

// Register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_OUTPUT 8'h08
`define REG_PERIOD 8'h0C

// Field positions
`define CTRL_PD_BIT 0
`define ST_LOCK_BIT 0
`define ST_LOWPWR_BIT 1
`define ST_OVR_BIT 2
`define ST_GRAY_BIT 3
`define ST_DIFF_BIT 4
`define ST_DCE_BIT 5
`define OUT_OVR_BIT 12

// Reset values
`define CTRL_RESET 1'b0

// Responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- adc_out_pkg.sv
// Types shared by the output interface files
`default_nettype none
`include "adc_out_params.svh"
package adc_out_pkg;
  typedef struct packed {
    logic overrange;
    logic [`SAMPLE_W-1:0] bits;
  } out_word_t;

  typedef enum logic [2:0] {
    STB_OFF = 3'h1,
    STB_LOW = 3'h2,
    STB_HIGH = 3'h4
  } strobe_state_t;
endpackage
`default_nettype wire

//--- pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinLevel
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        pinLevel[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        pinLevel[i] <= s3_q[i];
      end
    end
  end
endmodule
`default_nettype wire

//--- sample_coder.sv
// Clamp, overrange and output coding of one sample
`default_nettype none
`include "adc_out_params.svh"
module sample_coder #(
  parameter int ANALOG_W = `ANALOG_W_DEF
) (
  input wire logic signed [ANALOG_W-1:0] analogIn,
  input wire logic grayMode,
  output adc_out_pkg::out_word_t word
);
  localparam logic signed [ANALOG_W-1:0] MAXV = ANALOG_W'(`CODE_MAX);
  localparam logic signed [ANALOG_W-1:0] MINV = ANALOG_W'(`CODE_MIN);

  logic signed [ANALOG_W-1:0] clamped;
  logic ovr;
  logic [`SAMPLE_W-1:0] twos;
  logic [`SAMPLE_W-1:0] offs;
  logic [`SAMPLE_W-1:0] gray;

  if (ANALOG_W < `SAMPLE_W + 1) begin : g_bad_width
    $error("sample_coder: ANALOG_W too small");
  end

  always_comb begin
    clamped = analogIn;
    ovr = 1'b0;
    if (analogIn > MAXV) begin
      clamped = MAXV;
      ovr = 1'b1;
    end else if (analogIn < MINV) begin
      clamped = MINV;
      ovr = 1'b1;
    end
  end

  assign twos = clamped[`SAMPLE_W-1:0];
  assign offs = twos ^ `GRAY_OFFSET;

  // Binary to Gray, top bit passes through
  assign gray[`SAMPLE_W-1] = offs[`SAMPLE_W-1];
  for (genvar i = 0; i < `SAMPLE_W - 1; i++) begin : g_gray
    assign gray[i] = offs[i] ^ offs[i+1];
  end

  assign word = {ovr, grayMode ? gray : twos};
endmodule
`default_nettype wire

//--- adc_parallel_output_interface.sv
// Converter parallel output stage with strobe, overrange and register slave
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`default_nettype none
`include "adc_out_params.svh"
module adc_parallel_output_interface #(
  parameter int ANALOG_W = `ANALOG_W_DEF,
  parameter int PIPE_DEPTH = `PIPE_DEPTH,
  parameter int DAV_DELAY_CYC = `DAV_DELAY_CYC,
  parameter int LOCK_CYCLES = `LOCK_CYCLES,
  parameter int PERIOD_W = `PERIOD_W,
  parameter int AXI_AW = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clockInPos,
  input wire logic clockInNeg,
  input wire logic clockTypeSelect,
  input wire logic dutyEqualizerEnable,
  input wire logic formatSelect,
  input wire logic powerdownIn,
  input wire logic signed [ANALOG_W-1:0] analogIn,
  output logic [`SAMPLE_W-1:0] sampleBits,
  output logic sampleBitsOe,
  output logic overrangeFlag,
  output logic overrangeFlagOe,
  output logic dataValidStrobe,
  output logic dataValidStrobeOe,
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  if (ANALOG_W < `SAMPLE_W + 1 || PIPE_DEPTH < 2 || DAV_DELAY_CYC < 1 ||
      LOCK_CYCLES < 1 || PERIOD_W < 4 || AXI_AW < 4 ||
      LOCK_CYCLES >= (1 << PERIOD_W)) begin : g_bad_params
    $error("adc_parallel_output_interface: unsupported parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and conversion clock edges
  logic [5:0] pinRaw;
  logic [5:0] pinLvl;
  logic posLvl;
  logic negLvl;
  logic diffClk;
  logic dceOn;
  logic grayOn;
  logic pdLvl;
  logic ctrlPd_q;
  logic lowPower;
  logic convLevel;
  logic convPrev_q;
  logic convFall;
  logic convRise;

  assign pinRaw = {powerdownIn, formatSelect, dutyEqualizerEnable, clockTypeSelect,
                   clockInNeg, clockInPos};

  pin_sync #(.W(6)) uPinSync (
    .clk(clk),
    .rstn(rstn),
    .pinIn(pinRaw),
    .pinLevel(pinLvl)
  );

  assign posLvl = pinLvl[0];
  assign negLvl = pinLvl[1];
  assign diffClk = pinLvl[2];
  assign dceOn = pinLvl[3];
  assign grayOn = pinLvl[4];
  assign pdLvl = pinLvl[5];
  assign lowPower = pdLvl | ctrlPd_q;

  // Differential clock is high when the positive leg leads
  assign convLevel = diffClk ? (posLvl & ~negLvl) : posLvl;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      convPrev_q <= 1'b0;
    end else begin
      convPrev_q <= convLevel;
    end
  end

  assign convFall = convPrev_q & ~convLevel;
  assign convRise = ~convPrev_q & convLevel;

  ////////////////////////////////////////////////////////////////////////////
  // Sample pipeline, advanced on each falling edge outside low power and held at zero in low power
  logic signed [ANALOG_W-1:0] pipe_q [PIPE_DEPTH];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= '0;
      end
    end else if (lowPower) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= '0;
      end
    end else if (convFall) begin
      pipe_q[0] <= analogIn;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period measurement and equalizer lock
  logic [PERIOD_W-1:0] periodCnt_q;
  logic [PERIOD_W-1:0] period_q;
  logic [PERIOD_W-1:0] newPeriod;
  logic [PERIOD_W-1:0] lockCnt_q;
  logic [PERIOD_W-1:0] halfPeriod;
  logic freqChange;
  logic dllLocked;

  assign newPeriod = PERIOD_W'(periodCnt_q + 1'b1);
  assign freqChange = (newPeriod > PERIOD_W'(period_q + 1'b1)) ||
                      (period_q > PERIOD_W'(newPeriod + 1'b1));
  assign halfPeriod = (period_q >> 1) == '0 ? PERIOD_W'(1) : (period_q >> 1);
  assign dllLocked = lockCnt_q == PERIOD_W'(LOCK_CYCLES);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      periodCnt_q <= '0;
      period_q <= '0;
    end else if (convFall) begin
      periodCnt_q <= '0;
      period_q <= newPeriod;
    end else if (periodCnt_q != '1) begin
      periodCnt_q <= PERIOD_W'(periodCnt_q + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lockCnt_q <= '0;
    end else if (lowPower || !dceOn) begin
      lockCnt_q <= '0;
    end else if (convFall) begin
      if (freqChange) begin
        lockCnt_q <= '0;
      end else if (!dllLocked) begin
        lockCnt_q <= PERIOD_W'(lockCnt_q + 1'b1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe generation and output word
  logic [DAV_DELAY_CYC-1:0] fallDly_q;
  logic [DAV_DELAY_CYC-1:0] riseDly_q;
  logic [PERIOD_W-1:0] highCnt_q;
  adc_out_pkg::strobe_state_t strobe_q;
  adc_out_pkg::out_word_t coded;
  adc_out_pkg::out_word_t outWord_q;
  logic davRise;
  logic davEnd;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fallDly_q <= '0;
      riseDly_q <= '0;
    end else begin
      fallDly_q[0] <= convFall;
      riseDly_q[0] <= convRise;
      for (int i = 1; i < DAV_DELAY_CYC; i++) begin
        fallDly_q[i] <= fallDly_q[i-1];
        riseDly_q[i] <= riseDly_q[i-1];
      end
    end
  end

  assign davRise = fallDly_q[DAV_DELAY_CYC-1];
  assign davEnd = dceOn ? (highCnt_q <= PERIOD_W'(1)) : riseDly_q[DAV_DELAY_CYC-1];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_q <= adc_out_pkg::STB_OFF;
    end else begin
      case (strobe_q)
        adc_out_pkg::STB_OFF: begin
          if (!lowPower) begin
            strobe_q <= adc_out_pkg::STB_LOW;
          end
        end
        adc_out_pkg::STB_LOW: begin
          if (lowPower) begin
            strobe_q <= adc_out_pkg::STB_OFF;
          end else if (davRise) begin
            strobe_q <= adc_out_pkg::STB_HIGH;
          end
        end
        adc_out_pkg::STB_HIGH: begin
          if (lowPower) begin
            strobe_q <= adc_out_pkg::STB_OFF;
          end else if (davEnd) begin
            strobe_q <= adc_out_pkg::STB_LOW;
          end
        end
        default: begin
          strobe_q <= adc_out_pkg::STB_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      highCnt_q <= '0;
    end else if (strobe_q == adc_out_pkg::STB_LOW && davRise) begin
      highCnt_q <= halfPeriod;
    end else if (strobe_q == adc_out_pkg::STB_HIGH && highCnt_q != '0) begin
      highCnt_q <= PERIOD_W'(highCnt_q - 1'b1);
    end
  end

  sample_coder #(.ANALOG_W(ANALOG_W)) uCoder (
    .analogIn(pipe_q[PIPE_DEPTH-1]),
    .grayMode(grayOn),
    .word(coded)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outWord_q <= '0;
    end else if (strobe_q == adc_out_pkg::STB_HIGH && davEnd && !lowPower) begin
      outWord_q <= coded;
    end
  end

  assign sampleBits = outWord_q.bits;
  assign overrangeFlag = outWord_q.overrange;
  assign dataValidStrobe = strobe_q == adc_out_pkg::STB_HIGH;
  // Enables follow the raw pin so the float meets its bound
  assign sampleBitsOe = ~(powerdownIn | ctrlPd_q);
  assign overrangeFlagOe = ~(powerdownIn | ctrlPd_q);
  assign dataValidStrobeOe = ~(powerdownIn | ctrlPd_q);

  ////////////////////////////////////////////////////////////////////////////
  // Register slave
  logic awHeld_q;
  logic wHeld_q;
  logic [AXI_AW-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] statusWord;

  assign awready = ~awHeld_q & ~bvalid_q;
  assign wready = ~wHeld_q & ~bvalid_q;
  assign arready = ~rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  assign statusWord = {26'h0, dceOn, diffClk, grayOn, outWord_q.overrange, lowPower,
                       dllLocked};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      ctrlPd_q <= `CTRL_RESET;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (awHeld_q && wHeld_q && !bvalid_q) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= `RESP_OKAY;
        case ({awAddr_q[AXI_AW-1:2], 2'h0})
          AXI_AW'(`REG_CTRL): begin
            if (wStrb_q[0]) begin
              ctrlPd_q <= wData_q[`CTRL_PD_BIT];
            end
          end
          AXI_AW'(`REG_STATUS), AXI_AW'(`REG_OUTPUT), AXI_AW'(`REG_PERIOD): begin
            bresp_q <= `RESP_OKAY;
          end
          default: begin
            bresp_q <= `RESP_SLVERR;
          end
        endcase
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= `RESP_OKAY;
      case ({araddr[AXI_AW-1:2], 2'h0})
        AXI_AW'(`REG_CTRL): rdata_q <= {31'h0, ctrlPd_q};
        AXI_AW'(`REG_STATUS): rdata_q <= statusWord;
        AXI_AW'(`REG_OUTPUT): rdata_q <= {19'h0, outWord_q};
        AXI_AW'(`REG_PERIOD): rdata_q <= 32'(period_q);
        default: begin
          rdata_q <= 32'h0;
          rresp_q <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- adc_parallel_output_interface_asserts.sv
// Pin-level checks on the converter output stage
`default_nettype none
module adc_parallel_output_interface_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic powerdownIn,
  input wire logic clockInPos,
  input wire logic dutyEqualizerEnable,
  input wire logic [11:0] sampleBits,
  input wire logic sampleBitsOe,
  input wire logic overrangeFlag,
  input wire logic overrangeFlagOe,
  input wire logic dataValidStrobe,
  input wire logic dataValidStrobeOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence pdHeld;
    powerdownIn [*6];
  endsequence
  sequence offFall;
    $fell(dataValidStrobe) && !dutyEqualizerEnable && !$past(dutyEqualizerEnable, 6) &&
      sampleBitsOe && $past(sampleBitsOe, 6);
  endsequence
  AST_BITS_OE: assert property (powerdownIn |-> !sampleBitsOe)
    else $error("sample bits driven in power-down");
  AST_DOR_OE: assert property (powerdownIn |-> !overrangeFlagOe)
    else $error("overrange driven in power-down");
  AST_DAV_OE: assert property (powerdownIn |-> !dataValidStrobeOe)
    else $error("strobe driven in power-down");
  AST_PD_STROBE: assert property (pdHeld |-> !dataValidStrobe)
    else $error("strobe active in power-down");
  AST_BITS_AT_FALL: assert property ($changed(sampleBits) |-> $fell(dataValidStrobe))
    else $error("bits changed away from strobe fall");
  AST_DOR_AT_FALL: assert property ($changed(overrangeFlag) |-> $fell(dataValidStrobe))
    else $error("overrange changed away from strobe fall");
  AST_RISE_AFTER_CLK_FALL: assert property ($rose(dataValidStrobe) |-> !$past(clockInPos, 3))
    else $error("strobe rose without clock fall");
  AST_FALL_AFTER_CLK_RISE: assert property (offFall |-> $past(clockInPos, 2))
    else $error("strobe fell without clock rise");
endmodule
bind adc_parallel_output_interface adc_parallel_output_interface_asserts u_asserts (
  .clk, .rstn, .powerdownIn, .clockInPos, .dutyEqualizerEnable, .sampleBits, .sampleBitsOe,
  .overrangeFlag, .overrangeFlagOe, .dataValidStrobe, .dataValidStrobeOe);
`default_nettype wire

//--- backend_capture_model.sv
// Back-end capture logic latching the converter word
`default_nettype none
module backend_capture_model (
  input wire logic strobe,
  input wire logic strobeOe,
  input wire logic busOe,
  input wire logic [11:0] bits,
  input wire logic ovr,
  input wire logic convClk,
  output logic [12:0] capWord,
  output logic [12:0] fallWord,
  output logic capToggle,
  output logic [12:0] busLevel,
  output logic strobeLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] lastDriven = 13'h0000;
  initial capToggle = 1'b0;
  // Pull-down on the strobe line
  assign strobeLevel = strobeOe & strobe;
  always @(bits or ovr or busOe) if (busOe) lastDriven = {ovr, bits};
  // Released bus shows inverse of last value
  assign busLevel = busOe ? {ovr, bits} : ~lastDriven;
  always @(posedge strobeLevel) begin
    capWord = busLevel;
    capToggle = ~capToggle;
  end
  always @(negedge convClk) fallWord = busLevel;
endmodule
`default_nettype wire

//--- adc_parallel_output_interface_tb.sv
// Self-checking bench for the converter output stage
`default_nettype none
`include "adc_out_params.svh"
module adc_parallel_output_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clockInPos = 1'b0;
  logic clockInNeg = 1'b0;
  logic clockTypeSelect = 1'b0;
  logic dutyEqualizerEnable = 1'b0;
  logic formatSelect = 1'b0;
  logic powerdownIn = 1'b0;
  logic signed [13:0] analogIn = 14'sh0000;
  logic [11:0] sampleBits;
  logic sampleBitsOe, overrangeFlag, overrangeFlagOe, dataValidStrobe, dataValidStrobeOe;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, capToggle, strobeLevel;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [12:0] capWord, busLevel, fallWord, expCap, expFall;
  int mismatches = 0, cmpCount = 0, fallCount = 0, highNs = 40, periodNs = 80;
  logic checking = 1'b0;
  logic [12:0] hist [64];
  logic signed [13:0] vals [8] = '{14'sh07FF, 14'sh0800, 14'sh3800, 14'sh37FF, 14'sh0000,
    14'sh3FFF, 14'sh0005, 14'sh2000};

  always #4 clk = ~clk;

  adc_parallel_output_interface u_dut (.*);

  backend_capture_model u_backend (.strobe(dataValidStrobe), .strobeOe(dataValidStrobeOe),
    .busOe(sampleBitsOe), .bits(sampleBits), .ovr(overrangeFlag), .convClk(clockInPos),
    .capWord(capWord), .fallWord(fallWord), .capToggle(capToggle), .busLevel(busLevel),
    .strobeLevel(strobeLevel));

  initial begin
    #3;
    forever begin
      clockInPos = 1'b1;
      clockInNeg = 1'b0;
      #(highNs);
      clockInPos = 1'b0;
      clockInNeg = clockTypeSelect;
      #(periodNs - highNs);
    end
  end

  function automatic logic [12:0] expWord(input logic signed [13:0] v, input logic g);
    logic [11:0] b;
    b = (v > 14'sh07FF) ? 12'h7FF : ((v < 14'sh3800) ? 12'h800 : v[11:0]);
    if (g) begin
      b = b ^ 12'h800;
      b = b ^ (b >> 1);
    end
    return {(v > 14'sh07FF) || (v < 14'sh3800), b};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  always @(posedge clockInPos) analogIn <= vals[fallCount % 8];
  always @(negedge clockInPos) begin
    hist[fallCount % 64] = expWord(analogIn, formatSelect);
    fallCount++;
  end
  always @(capToggle) begin
    if (checking && fallCount >= 10) begin
      expCap = hist[(fallCount - 10) % 64];
      chk("word", 32'(expCap), 32'(capWord));
    end
    if (checking && fallCount >= 11) begin
      expFall = hist[(fallCount - 11) % 64];
      chk("fall word", 32'(expFall), 32'(fallWord));
    end
  end

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && (awready === 1'b1);
      tw = wvalid && (wready === 1'b1);
      tb = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && (arready === 1'b1);
      tr = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask

  task automatic setMode(input logic g, input logic e, input logic df);
    @(posedge clk);
    formatSelect <= g;
    dutyEqualizerEnable <= e;
    clockTypeSelect <= df;
  endtask

  task automatic runStream(input logic g, input logic e, input logic df);
    logic [31:0] d;
    logic [1:0] r;
    setMode(g, e, df);
    checking = 1'b0;
    repeat (2) @(posedge clockInPos);
    fallCount = 0;
    checking = 1'b1;
    repeat (18) @(posedge clockInPos);
    @(posedge dataValidStrobe);
    axiRead(`REG_OUTPUT, d, r);
    chk("output reg", {19'h0, hist[(fallCount - 10) % 64]}, d);
    axiRead(`REG_PERIOD, d, r);
    chk("period reg", periodNs / 8, d);
    checking = 1'b0;
  endtask

  task automatic regCheck();
    logic [31:0] d;
    logic [1:0] r;
    setMode(1'b1, 1'b0, 1'b1);
    axiRead(`REG_CTRL, d, r);
    chk("ctrl reset", 32'h0, d);
    axiWrite(`REG_CTRL, 32'h1, r);
    @(negedge clk);
    chk("soft pd oe", 32'h0, {sampleBitsOe, overrangeFlagOe, dataValidStrobeOe});
    axiRead(`REG_CTRL, d, r);
    chk("ctrl back", 32'h1, d);
    axiRead(`REG_STATUS, d, r);
    chk("status lowpwr", 32'h1, d[`ST_LOWPWR_BIT]);
    axiWrite(`REG_CTRL, 32'h0, r);
    axiWrite(`REG_STATUS, 32'hFFFFFFFF, r);
    chk("ro resp", `RESP_OKAY, r);
    axiRead(`REG_STATUS, d, r);
    chk("status mode", 32'h3, d[5:3]);
    axiRead(8'h10, d, r);
    chk("unmapped resp", `RESP_SLVERR, r);
    chk("unmapped data", 32'h0, d);
    axiWrite(8'h10, 32'h0, r);
    chk("unmapped wresp", `RESP_SLVERR, r);
  endtask

  task automatic dceWidth(input int h);
    int w;
    highNs = h;
    repeat (3) @(posedge clockInPos);
    @(posedge dataValidStrobe);
    w = 0;
    @(negedge clk);
    while (dataValidStrobe === 1'b1 && w < 50) begin
      w++;
      @(negedge clk);
    end
    chk("strobe width", periodNs / 16, w);
  endtask

  task automatic lockCheck();
    logic [31:0] d;
    logic [1:0] r;
    repeat (110) @(posedge clockInPos);
    axiRead(`REG_STATUS, d, r);
    chk("locked", 32'h1, d[0]);
    periodNs = 96;
    highNs = 48;
    repeat (3) @(posedge clockInPos);
    axiRead(`REG_STATUS, d, r);
    chk("relock start", 32'h0, d[0]);
    repeat (110) @(posedge clockInPos);
    axiRead(`REG_STATUS, d, r);
    chk("relocked", 32'h1, d[0]);
    periodNs = 80;
    highNs = 40;
  endtask

  task automatic pdCheck();
    @(posedge clk);
    powerdownIn <= 1'b1;
    @(negedge clk);
    chk("pd oe", 32'h0, {sampleBitsOe, overrangeFlagOe, dataValidStrobeOe});
    repeat (3) @(posedge clockInPos);
    @(posedge clk);
    powerdownIn <= 1'b0;
    @(negedge clk);
    chk("wake oe", 32'h7, {sampleBitsOe, overrangeFlagOe, dataValidStrobeOe});
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", mismatches, cmpCount);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    $display("[ERR] watchdog expected finish seen hang");
    conclude();
  end

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    regCheck();
    for (int i = 0; i < 4; i++) begin
      runStream(i[0], i[1], i[0]);
    end
    setMode(1'b0, 1'b1, 1'b0);
    dceWidth(44);
    dceWidth(36);
    lockCheck();
    pdCheck();
    runStream(1'b1, 1'b0, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
